/* hw/frocmd_pkg.sv */
// Package of constants and types for the read-once command sequencer
package frocmd_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] STAT_OFS   = 8'h00;
  localparam logic [7:0] IDX_OFS    = 8'h04;
  localparam logic [7:0] DATA_OFS   = 8'h08;
  localparam logic [7:0] CMD_OFS    = 8'h0c;
  localparam logic [7:0] MODE_OFS   = 8'h10;
  localparam logic [7:0] ISTAT_OFS  = 8'h14;
  localparam logic [7:0] ICLR_OFS   = 8'h18;
  localparam logic [7:0] IEN_OFS    = 8'h1c;

  // ==========================================================================
  // Status register field positions
  localparam int CCF_BIT  = 7;
  localparam int ACC_BIT  = 5;
  localparam int PV_BIT   = 4;
  localparam int RE1_BIT  = 1;
  localparam int RE0_BIT  = 0;
  localparam int ISTAT_DONE_BIT = 0;
  localparam int ISTAT_ERR_BIT  = 1;

  // ==========================================================================
  // Command codes and index values
  localparam logic [7:0]  CMD_READ_ONCE = 8'h04;
  localparam logic [7:0]  CMD_LOAD_DATA = 8'h05;
  localparam logic [2:0]  IX_CMD        = 3'h0;
  localparam logic [2:0]  IX_PHRASE     = 3'h1;
  localparam logic [2:0]  IX_WORD0      = 3'h2;
  localparam logic [2:0]  IX_WORD3      = 3'h5;
  localparam logic [15:0] PHRASE_MAX    = 16'h0007;
  localparam int          FIELD_BYTES   = 64;
  localparam int          PHRASES       = 8;
  localparam int          WORDS_PER_PH  = 4;

  // ==========================================================================
  // Reset values and timing
  localparam logic        CCF_RST       = 1'b1;
  localparam logic [1:0]  MODE_RST      = 2'h0;
  localparam int          FETCH_CYCLES  = 4;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    FRO_IDLE  = 2'b00,
    FRO_FETCH = 2'b01,
    FRO_STORE = 2'b10
  } frocmd_state_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] phrase;
  } frocmd_req_s;

  typedef struct packed {
    logic        done;
    logic [63:0] data;
    logic        err_any;
    logic        err_unc;
  } frocmd_rsp_s;

endpackage : frocmd_pkg

/* hw/frocmd_otp.sv */
// One-time field store: 8 phrases of 64 bits with error-check reporting
`timescale 1ns/10ps
module frocmd_otp (
  input  wire logic               CLK,
  input  wire logic               SYS_RST,
  input  wire frocmd_pkg::frocmd_req_s req,
  input  wire logic [7:0]         err_inject,
  input  wire logic [7:0]         unc_inject,
  output      frocmd_pkg::frocmd_rsp_s rsp
);

  // ==========================================================================
  // Storage array; contents set by the program-once path, a fixed per-phrase pattern here
  logic [63:0] field_mem [frocmd_pkg::PHRASES];
  logic [2:0]  cnt_r;
  logic        busy_r;
  logic [2:0]  ph_r;

  // Fixed pattern {3+i, 2, 1, i} per phrase until programmed elsewhere
  always_comb begin
    for (int i = 0; i < frocmd_pkg::PHRASES; i++) begin
      field_mem[i] = {16'h0003 + 16'(i), 16'h0002, 16'h0001, 16'(i)};
    end
  end

  // Multi-cycle array access, the array is slow compared with the bus
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy_r <= 1'b0;
      cnt_r  <= 3'h0;
      ph_r   <= 3'h0;
      rsp    <= '0;
    end else begin
      rsp.done <= 1'b0;
      if (req.valid && !busy_r) begin
        busy_r <= 1'b1;
        ph_r   <= req.phrase;
        cnt_r  <= 3'(frocmd_pkg::FETCH_CYCLES - 1);
      end else if (busy_r) begin
        if (cnt_r == 3'h0) begin
          busy_r      <= 1'b0;
          rsp.done    <= 1'b1;
          rsp.data    <= field_mem[ph_r];
          rsp.err_any <= err_inject[ph_r] | unc_inject[ph_r];
          rsp.err_unc <= unc_inject[ph_r];
        end else begin
          cnt_r <= cnt_r - 3'h1;
        end
      end
    end
  end

endmodule : frocmd_otp

/* hw/frocmd_top.sv */
// Read-once command sequencer with register port and interrupt logic
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
module frocmd_top (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output      logic [31:0] RDATA,
  input  wire logic [7:0]  ERR_INJECT,
  input  wire logic [7:0]  UNC_INJECT,
  input  wire logic        BLK0_RD,
  output      logic        BLK0_INVALID,
  output      logic        BUSY,
  output      logic        IRQ
);

  // ==========================================================================
  // State
  frocmd_pkg::frocmd_state_e state_r;
  frocmd_pkg::frocmd_req_s   req_r;
  frocmd_pkg::frocmd_rsp_s   rsp;
  logic [15:0] command_object_words [6];
  logic [2:0]  command_object_index_r;
  logic        command_complete_flag_r;
  logic        access_error_flag_r;
  logic        protection_violation_flag_r;
  logic        read_error_any_r;
  logic        read_error_uncorrectable_r;
  logic [1:0]  mode_r;
  logic        load_active_r;
  logic [1:0]  int_stat_r;
  logic [1:0]  int_en_r;
  logic        launch;
  logic        bad_launch;
  logic        set_done;
  logic        set_err;

  // Register hit decode shared by both strobes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ==========================================================================
  // Launch decode: write of one to the complete flag clears it
  assign launch = WR_STB && hit(ADDR, frocmd_pkg::STAT_OFS) && WDATA[frocmd_pkg::CCF_BIT]
                  && command_complete_flag_r
                  && command_object_words[frocmd_pkg::IX_CMD][7:0]
                     == frocmd_pkg::CMD_READ_ONCE;

  // Any launch-time fault blocks the array access
  assign bad_launch = (command_object_index_r != frocmd_pkg::IX_PHRASE)
                    || load_active_r
                    || (mode_r != frocmd_pkg::MODE_RST)
                    || (command_object_words[frocmd_pkg::IX_PHRASE]
                        > frocmd_pkg::PHRASE_MAX);

  assign set_done = (launch && bad_launch) || (state_r == frocmd_pkg::FRO_STORE);
  assign set_err  = launch && bad_launch;

  // ==========================================================================
  // Sequencer
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= frocmd_pkg::FRO_IDLE;
      req_r   <= '0;
    end else begin
      req_r.valid <= 1'b0;
      unique case (state_r)
        frocmd_pkg::FRO_IDLE: begin
          if (launch && !bad_launch) begin
            req_r.valid  <= 1'b1;
            req_r.phrase <= command_object_words[frocmd_pkg::IX_PHRASE][2:0];
            state_r      <= frocmd_pkg::FRO_FETCH;
          end
        end
        frocmd_pkg::FRO_FETCH: begin
          if (rsp.done) begin
            state_r <= frocmd_pkg::FRO_STORE;
          end
        end
        frocmd_pkg::FRO_STORE: begin
          state_r <= frocmd_pkg::FRO_IDLE;
        end
        default: begin
          state_r <= frocmd_pkg::FRO_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Array model
  frocmd_otp u_otp (
    .CLK        (CLK),
    .SYS_RST    (SYS_RST),
    .req        (req_r),
    .err_inject (ERR_INJECT),
    .unc_inject (UNC_INJECT),
    .rsp        (rsp)
  );

  // ==========================================================================
  // Command complete flag: clear launches, set on finish or refusal
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      command_complete_flag_r <= frocmd_pkg::CCF_RST;
    end else if (set_done) begin
      command_complete_flag_r <= 1'b1;
    end else if (launch) begin
      command_complete_flag_r <= 1'b0;
    end
  end

  // Error flags: set wins over a same-cycle write-one clear
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      access_error_flag_r         <= 1'b0;
      protection_violation_flag_r <= 1'b0;
      read_error_any_r            <= 1'b0;
      read_error_uncorrectable_r  <= 1'b0;
    end else begin
      if (launch) begin
        read_error_any_r           <= 1'b0;
        read_error_uncorrectable_r <= 1'b0;
      end else if (state_r == frocmd_pkg::FRO_FETCH && rsp.done) begin
        read_error_any_r           <= rsp.err_any;
        read_error_uncorrectable_r <= rsp.err_unc;
      end
      if (set_err) begin
        access_error_flag_r <= 1'b1;
      end else if (WR_STB && hit(ADDR, frocmd_pkg::STAT_OFS) && WDATA[frocmd_pkg::ACC_BIT]) begin
        access_error_flag_r <= 1'b0;
      end
      if (WR_STB && hit(ADDR, frocmd_pkg::STAT_OFS) && WDATA[frocmd_pkg::PV_BIT]) begin
        protection_violation_flag_r <= 1'b0; // Never set by this command
      end
    end
  end

  // ==========================================================================
  // Index and data words; locked while a command is running
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      command_object_index_r <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        command_object_words[i] <= 16'h0000;
      end
    end else if (state_r == frocmd_pkg::FRO_FETCH && rsp.done) begin
      for (int w = 0; w < frocmd_pkg::WORDS_PER_PH; w++) begin
        command_object_words[int'(frocmd_pkg::IX_WORD0) + w]
          <= rsp.data[63 - 16*w -: 16];
      end
    end else if (WR_STB && command_complete_flag_r) begin
      if (hit(ADDR, frocmd_pkg::IDX_OFS)) begin
        command_object_index_r <= WDATA[2:0];
      end
      if (hit(ADDR, frocmd_pkg::DATA_OFS) && command_object_index_r <= frocmd_pkg::IX_WORD3) begin
        command_object_words[command_object_index_r] <= WDATA[15:0];
      end
    end
  end

  // Load-data-field sequence stays open until another code is written to the command register
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      load_active_r <= 1'b0;
    end else if (WR_STB && hit(ADDR, frocmd_pkg::CMD_OFS)) begin
      load_active_r <= (WDATA[7:0] == frocmd_pkg::CMD_LOAD_DATA);
    end
  end

  // Operating mode selector; nonzero modes forbid the command
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_r <= frocmd_pkg::MODE_RST;
    end else if (WR_STB && hit(ADDR, frocmd_pkg::MODE_OFS)) begin
      mode_r <= WDATA[1:0];
    end
  end

  // ==========================================================================
  // Interrupt status, clear and enable
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      int_stat_r <= 2'h0;
      int_en_r   <= 2'h0;
      IRQ        <= 1'b0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == frocmd_pkg::ISTAT_DONE_BIT && set_done) ||
            (b == frocmd_pkg::ISTAT_ERR_BIT && set_err)) begin
          int_stat_r[b] <= 1'b1; // Set wins over clear
        end else if (WR_STB && hit(ADDR, frocmd_pkg::ICLR_OFS) && WDATA[b]) begin
          int_stat_r[b] <= 1'b0;
        end
      end
      if (WR_STB && hit(ADDR, frocmd_pkg::IEN_OFS)) begin
        int_en_r <= WDATA[1:0];
      end
      IRQ <= |(int_stat_r & int_en_r);
    end
  end

  // ==========================================================================
  // Status outputs and block 0 read guard
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BUSY         <= 1'b0;
      BLK0_INVALID <= 1'b0;
    end else begin
      BUSY         <= (state_r != frocmd_pkg::FRO_IDLE) || (launch && !bad_launch);
      BLK0_INVALID <= BLK0_RD && (state_r != frocmd_pkg::FRO_IDLE);
    end
  end

  // ==========================================================================
  // Read port, one cycle latency; unmapped reads give zero
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD_STB) begin
      RDATA <= 32'h0000_0000;
      if (hit(ADDR, frocmd_pkg::STAT_OFS)) begin
        RDATA[frocmd_pkg::CCF_BIT] <= command_complete_flag_r;
        RDATA[frocmd_pkg::ACC_BIT] <= access_error_flag_r;
        RDATA[frocmd_pkg::PV_BIT]  <= protection_violation_flag_r;
        RDATA[frocmd_pkg::RE1_BIT] <= read_error_any_r;
        RDATA[frocmd_pkg::RE0_BIT] <= read_error_uncorrectable_r;
      end else if (hit(ADDR, frocmd_pkg::IDX_OFS)) begin
        RDATA[2:0] <= command_object_index_r;
      end else if (hit(ADDR, frocmd_pkg::DATA_OFS)) begin
        if (command_object_index_r <= frocmd_pkg::IX_WORD3) begin
          RDATA[15:0] <= command_object_words[command_object_index_r];
        end
      end else if (hit(ADDR, frocmd_pkg::MODE_OFS)) begin
        RDATA[1:0] <= mode_r;
      end else if (hit(ADDR, frocmd_pkg::ISTAT_OFS)) begin
        RDATA[1:0] <= int_stat_r;
      end else if (hit(ADDR, frocmd_pkg::IEN_OFS)) begin
        RDATA[1:0] <= int_en_r;
      end
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule : frocmd_top

/* verif/frocmd_props.sv */
// Port-level checker for the read-once sequencer
`timescale 1ns/10ps
module frocmd_props (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  ADDR,
  input wire logic        WR_STB,
  input wire logic        RD_STB,
  input wire logic [31:0] RDATA,
  input wire logic        BLK0_RD,
  input wire logic        BLK0_INVALID,
  input wire logic        BUSY,
  input wire logic        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // ==========================================================================
  // Fetch span: at least four busy cycles, then done within five more
  sequence s_fetch;
    BUSY [*4] ##[1:5] !BUSY;
  endsequence
  property p_launch_cause;
    $rose(BUSY) |-> $past(WR_STB && ADDR == frocmd_pkg::STAT_OFS)
      || $past(WR_STB && ADDR == frocmd_pkg::STAT_OFS, 2);
  endproperty
  property p_fetch_span;
    $rose(BUSY) |-> s_fetch;
  endproperty
  property p_fetch_min;
    $fell(BUSY) |-> $past(BUSY, 4);
  endproperty
  a_launch_cause: assert property (p_launch_cause) else $error("busy without launch");
  a_fetch_span:   assert property (p_fetch_span) else $error("fetch span wrong");
  a_fetch_min:    assert property (p_fetch_min) else $error("fetch too short");

  // ==========================================================================
  // Block 0 reads during the command, read data idle level
  // Busy in the next cycle too, so the sequencer was still away from idle
  property p_blk0_inval;
    BLK0_RD && BUSY ##1 BUSY |-> BLK0_INVALID;
  endproperty
  property p_blk0_idle;
    BLK0_RD && !BUSY && !$past(BUSY) |=> !BLK0_INVALID;
  endproperty
  property p_blk0_cause;
    BLK0_INVALID |-> $past(BLK0_RD);
  endproperty
  property p_rdata_idle;
    !$past(RD_STB) |-> RDATA == 32'h0;
  endproperty
  // Interrupt only drops after a clear or enable write
  property p_irq_fall;
    $fell(IRQ) |-> $past(WR_STB) || $past(WR_STB, 2) || $past(WR_STB, 3);
  endproperty
  a_blk0_inval: assert property (p_blk0_inval) else $error("block read not flagged");
  a_blk0_idle:  assert property (p_blk0_idle) else $error("idle read flagged");
  a_blk0_cause: assert property (p_blk0_cause) else $error("flag without read");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_irq_fall:   assert property (p_irq_fall) else $error("interrupt dropped alone");
endmodule : frocmd_props

bind frocmd_top frocmd_props u_props (
  .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB),
  .RDATA(RDATA), .BLK0_RD(BLK0_RD), .BLK0_INVALID(BLK0_INVALID), .BUSY(BUSY), .IRQ(IRQ)
);

/* verif/frocmd_tb_top.sv */
// Self-checking bench for the read-once sequencer
`timescale 1ns/10ps
module frocmd_tb_top;
  logic        clk      = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wdata    = 32'h0;
  logic        wr_stb   = 1'b0;
  logic        rd_stb   = 1'b0;
  logic [7:0]  err_inj  = 8'h00;
  logic [7:0]  unc_inj  = 8'h00;
  logic        blk0_rd  = 1'b0;
  logic [31:0] rdata;
  logic        blk0_inv;
  logic        busy;
  logic        irq;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          cmp_count  = 0;

  // ==========================================================================
  // Clock and design
  initial begin
    forever #50 clk = ~clk;
  end
  frocmd_top uut (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .ERR_INJECT(err_inj),
    .UNC_INJECT(unc_inj), .BLK0_RD(blk0_rd), .BLK0_INVALID(blk0_inv), .BUSY(busy), .IRQ(irq));

  // ==========================================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // Data only stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    chk32(d, exp);
  endtask : rdchk
  // Command object loaded in the documented order; ix is the index left at launch
  task automatic launch(input logic [15:0] ph, input logic [2:0] ix);
    wr(frocmd_pkg::IDX_OFS, 32'h0);
    wr(frocmd_pkg::DATA_OFS, 32'h4);
    wr(frocmd_pkg::IDX_OFS, 32'h1);
    wr(frocmd_pkg::DATA_OFS, {16'h0, ph});
    wr(frocmd_pkg::IDX_OFS, {29'h0, ix});
    wr(frocmd_pkg::STAT_OFS, 32'h80);
  endtask : launch
  // Bounded poll of the complete flag
  task automatic wait_done;
    for (int i = 0; i < 30; i++) begin
      rd(frocmd_pkg::STAT_OFS, d);
      if (d[7] === 1'b1) break;
    end
    chk1(d[7], 1'b1);
  endtask : wait_done
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    #1 chk1(irq, exp);
  endtask : irq_chk
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Watchdog: about 600 cycles expected, fifty times that allowed
  initial begin
    #3_000_000;
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(frocmd_pkg::STAT_OFS, 32'h80);
    rdchk(frocmd_pkg::IDX_OFS, 32'h0);
    rdchk(frocmd_pkg::MODE_OFS, 32'h0);
    rdchk(8'h20, 32'h0);
    wr(frocmd_pkg::IEN_OFS, 32'h1);
    // Every phrase of the field, probing block 0 mid-fetch
    for (int p = 0; p < 8; p++) begin
      launch(p[15:0], 3'h1);
      @(posedge clk);
      blk0_rd <= 1'b1;
      @(posedge clk);
      blk0_rd <= 1'b0;
      #1 chk1(blk0_inv, 1'b1);
      chk1(busy, 1'b1);
      wait_done();
      rdchk(frocmd_pkg::STAT_OFS, 32'h80);
      for (int w = 0; w < 4; w++) begin
        wr(frocmd_pkg::IDX_OFS, 32'(w + 2));
        rdchk(frocmd_pkg::DATA_OFS, w == 0 ? p + 3 : (w == 3 ? p : 3 - w));
      end
    end
    @(posedge clk);
    blk0_rd <= 1'b1;
    @(posedge clk);
    blk0_rd <= 1'b0;
    #1 chk1(blk0_inv, 1'b0);
    // Done interrupt: raised, masked, cleared
    chk1(irq, 1'b1);
    rdchk(frocmd_pkg::ISTAT_OFS, 32'h1);
    wr(frocmd_pkg::IEN_OFS, 32'h0);
    irq_chk(1'b0);
    wr(frocmd_pkg::IEN_OFS, 32'h1);
    irq_chk(1'b1);
    wr(frocmd_pkg::ICLR_OFS, 32'h1);
    irq_chk(1'b0);
    rdchk(frocmd_pkg::ISTAT_OFS, 32'h0);
    // Read errors, correctable then uncorrectable
    @(posedge clk);
    err_inj <= 8'h08;
    unc_inj <= 8'h20;
    launch(16'h3, 3'h1);
    wait_done();
    rdchk(frocmd_pkg::STAT_OFS, 32'h82);
    launch(16'h5, 3'h1);
    wait_done();
    rdchk(frocmd_pkg::STAT_OFS, 32'h83);
    // Refused launches: index, open load sequence, mode, phrase range
    for (int c = 0; c < 5; c++) begin
      if (c == 1) wr(frocmd_pkg::CMD_OFS, 32'h5);
      if (c == 2) wr(frocmd_pkg::MODE_OFS, 32'h1);
      launch(c == 3 ? 16'h8 : (c == 4 ? 16'h100 : 16'h0), c == 0 ? 3'h2 : 3'h1);
      @(posedge clk);
      #1 chk1(busy, 1'b0);
      rdchk(frocmd_pkg::STAT_OFS, 32'ha0);
      wr(frocmd_pkg::CMD_OFS, 32'h0);
      wr(frocmd_pkg::MODE_OFS, 32'h0);
      wr(frocmd_pkg::STAT_OFS, 32'h20);
      rdchk(frocmd_pkg::STAT_OFS, 32'h80);
    end
    wr(frocmd_pkg::IDX_OFS, 32'h2);
    rdchk(frocmd_pkg::DATA_OFS, 32'h8);
    rdchk(frocmd_pkg::ISTAT_OFS, 32'h3);
    wr(frocmd_pkg::ICLR_OFS, 32'h1);
    wr(frocmd_pkg::IEN_OFS, 32'h2);
    irq_chk(1'b1);
    wr(frocmd_pkg::ICLR_OFS, 32'h3);
    irq_chk(1'b0);
    // Accepted launch clears stale error bits
    launch(16'h5, 3'h1);
    wait_done();
    rdchk(frocmd_pkg::STAT_OFS, 32'h83);
    @(posedge clk);
    err_inj <= 8'h00;
    unc_inj <= 8'h00;
    launch(16'h5, 3'h1);
    wait_done();
    rdchk(frocmd_pkg::STAT_OFS, 32'h80);
    // Wrong code in word 0 with a clean index: nothing starts, no error
    wr(frocmd_pkg::IDX_OFS, 32'h0);
    wr(frocmd_pkg::DATA_OFS, 32'h7);
    wr(frocmd_pkg::IDX_OFS, 32'h1);
    wr(frocmd_pkg::STAT_OFS, 32'h80);
    #1 chk1(busy, 1'b0);
    rdchk(frocmd_pkg::STAT_OFS, 32'h80);
    wrap_up();
  end
endmodule : frocmd_tb_top
